/* File: core/tcc_consts.svh */
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register addresses on the 8-bit io bus
`define TCC_ADDR_W        6
`define TCC_ADDR_CMP_B    6'h12
`define TCC_ADDR_CMP_A    6'h13
`define TCC_ADDR_CNT_H    6'h14
`define TCC_ADDR_CTRL_A   6'h15
`define TCC_ADDR_CNT_L    6'h32
`define TCC_ADDR_CTRL_B   6'h33
`define TCC_ADDR_FLAGS    6'h38
`define TCC_ADDR_MASK     6'h39

// control a bit positions
`define TCC_A_WIDTH       7
`define TCC_A_CAP_EN      6
`define TCC_A_FILT        5
`define TCC_A_EDGE        4
`define TCC_A_ACMP        3
`define TCC_A_CTC         0
`define TCC_CTRL_A_MASK   8'hf9

// control b bit positions
`define TCC_B_SYNC        4
`define TCC_B_PSR         3
`define TCC_B_CS_HI       2

// mask and flag bit positions
`define TCC_BIT_CMPA      4
`define TCC_BIT_CAP       0

// prescaler taps
`define TCC_PRE_W         10
`define TCC_PRE_ZERO      10'h000
`define TCC_PRE_ONE       10'h001
`define TCC_DIV8_MASK     10'h007
`define TCC_DIV64_MASK    10'h03f
`define TCC_DIV256_MASK   10'h0ff
`define TCC_DIV1024_MASK  10'h3ff

// counter limits and reset values
`define TCC_MAX16         16'hffff
`define TCC_MAX8          8'hff
`define TCC_ZERO16        16'h0000
`define TCC_ONE16         16'h0001
`define TCC_ZERO8         8'h00
`define TCC_ONE8          8'h01
`define TCC_ZERO3         3'h0
`define TCC_FILT_LEN      4
`define TCC_FILT_ONES     4'hf
`define TCC_FILT_ZEROS    4'h0

`endif

/* File: core/tcc_pkg.sv */
`default_nettype none
package tcc_pkg;

    typedef enum logic [2:0] {
        TCC_CS_STOP     = 3'h0,
        TCC_CS_IO       = 3'h1,
        TCC_CS_DIV8     = 3'h2,
        TCC_CS_DIV64    = 3'h3,
        TCC_CS_DIV256   = 3'h4,
        TCC_CS_DIV1024  = 3'h5,
        TCC_CS_EXT_FALL = 3'h6,
        TCC_CS_EXT_RISE = 3'h7
    } tcc_clk_sel_e;

    typedef struct packed {
        logic [7:0]   ctrl_a;
        tcc_clk_sel_e clk_sel;
        logic         sync_hold;
        logic         psr;
        logic         mask_cmpa;
        logic         mask_cap;
        logic         flag_cmpa;
        logic         flag_cap;
        logic [15:0]  counter;
        logic [7:0]   cmp_a;
        logic [7:0]   cmp_b;
        logic [7:0]   temp;
        logic [9:0]   pre;
        logic         ext_prev;
        logic         cap_prev;
        logic         block;
        logic [7:0]   rdata;
    } tcc_state_s;

    typedef struct packed {
        logic [3:0] sr;
        logic       out;
    } tcc_filt_s;

endpackage
`default_nettype wire

/* File: core/tcc_input_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_input_filter (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic sample_in,
    input  wire logic filter_enable,
    output logic      level_out
);

    tcc_pkg::tcc_filt_s s_q;
    tcc_pkg::tcc_filt_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.sr = {s_q.sr[`TCC_FILT_LEN-2:0], sample_in};
        if (!filter_enable) begin
            s_d.out = sample_in;
        end else if (s_q.sr == `TCC_FILT_ONES) begin
            s_d.out = 1'b1;
        end else if (s_q.sr == `TCC_FILT_ZEROS) begin
            s_d.out = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.out;

    property p_filt_change;
        @(posedge core_clk) disable iff (reset)
        $past(filter_enable) && $changed(level_out) |->
            $past(sample_in, 2) == level_out && $past(sample_in, 3) == level_out &&
            $past(sample_in, 4) == level_out && $past(sample_in, 5) == level_out;
    endproperty
    a_filt_change: assert property (p_filt_change)
        else $error("filtered level changed without four equal samples");

    property p_unfilt_delay;
        @(posedge core_clk) disable iff (reset)
        !$past(filter_enable) |-> level_out == $past(sample_in);
    endproperty
    a_unfilt_delay: assert property (p_unfilt_delay)
        else $error("unfiltered path is not one cycle");

endmodule
`default_nettype wire

/* File: core/tcc_timer0.sv */
// What this block does
// - width bit set runs a 16-bit counter against combined 16-bit compare.
// - capture enable bit switches the timer into input capture mode.
// - noise filter changes its output only after four equal samples.
// - filtered capture events arrive four clocks later than unfiltered.
// - edge bit zero captures on falling edge, one on rising edge.
// - capture copies counter low byte into compare a (high byte into compare b in 16-bit mode) and sets capture flag.
// - comparator capture bit routes comparator output into capture front end.
// - control a reserved bits two and one always read zero.
// - counting-mode bit picks free running or clear on compare match.
// - in sync mode the written prescaler reset value is kept, halting counter.
// - writing sync mode zero clears prescaler reset and counting resumes.
// - prescaler reset bit resets prescaler, self clears unless sync mode.
// - clock select chooses stop, io clock, or divide by 8/64/256/1024.
// - codes 110/111 count falling/rising external pin edges, even as output.
// - cpu write to counter low byte suppresses match on next timer tick.
// - 16-bit mode high bytes go through one shared holding register.
// - 8-bit mode compares compare a with counter low byte for match.
// - 16-bit compare value is compare b high byte, compare a low byte.
// - compare a interrupt requested while flag and its enable are set.
// - holding register keeps value between accesses, so high byte reusable.
// - low byte access moves the word: write loads both, counter read (compare read in capture mode) fills holding.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_timer0 (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic [`TCC_ADDR_W-1:0] io_addr,
    input  wire logic [7:0]            io_wdata,
    input  wire logic                  io_we,
    input  wire logic                  io_re,
    output logic      [7:0]            io_rdata,
    input  wire logic                  capture_pin,
    input  wire logic                  comparator_out,
    input  wire logic                  external_clock_pin,
    output logic                       compare_a_irq,
    output logic                       capture_irq
);

    tcc_pkg::tcc_state_s s_q;
    tcc_pkg::tcc_state_s s_d;

    logic        wr_ctrl_a;
    logic        wr_ctrl_b;
    logic        wr_mask;
    logic        wr_flags;
    logic        wr_cnt_l;
    logic        wr_cnt_h;
    logic        wr_cmp_a;
    logic        wr_cmp_b;
    logic        rd_cnt_l;
    logic        rd_cmp_a;
    logic        wide;
    logic        cap_mode;
    logic        ctc_mode;
    logic        edge_sel;
    logic        acmp_sel;
    logic        cap_src;
    logic        filt_level;
    logic        cap_edge;
    logic        capture;
    logic        pre_clear;
    logic        run;
    logic        ext_fall;
    logic        ext_rise;
    logic        tick;
    logic [15:0] cmp_val;
    logic [15:0] cnt_val;
    logic [15:0] top_val;
    logic        match;
    logic        at_top;
    logic        cmpa_set;

    assign wr_ctrl_a = io_we && (io_addr == `TCC_ADDR_CTRL_A);
    assign wr_ctrl_b = io_we && (io_addr == `TCC_ADDR_CTRL_B);
    assign wr_mask   = io_we && (io_addr == `TCC_ADDR_MASK);
    assign wr_flags  = io_we && (io_addr == `TCC_ADDR_FLAGS);
    assign wr_cnt_l  = io_we && (io_addr == `TCC_ADDR_CNT_L);
    assign wr_cnt_h  = io_we && (io_addr == `TCC_ADDR_CNT_H);
    assign wr_cmp_a  = io_we && (io_addr == `TCC_ADDR_CMP_A);
    assign wr_cmp_b  = io_we && (io_addr == `TCC_ADDR_CMP_B);
    assign rd_cnt_l  = io_re && (io_addr == `TCC_ADDR_CNT_L);
    assign rd_cmp_a  = io_re && (io_addr == `TCC_ADDR_CMP_A);

    assign wide     = s_q.ctrl_a[`TCC_A_WIDTH];
    assign cap_mode = s_q.ctrl_a[`TCC_A_CAP_EN];
    assign ctc_mode = s_q.ctrl_a[`TCC_A_CTC];
    assign edge_sel = s_q.ctrl_a[`TCC_A_EDGE];
    assign acmp_sel = s_q.ctrl_a[`TCC_A_ACMP];

    // capture front end: source select, filter, edge detect
    assign cap_src = acmp_sel ? comparator_out : capture_pin;

    tcc_input_filter u_filter (
        .core_clk      (core_clk),
        .reset         (reset),
        .sample_in     (cap_src),
        .filter_enable (s_q.ctrl_a[`TCC_A_FILT]),
        .level_out     (filt_level)
    );

    assign cap_edge = edge_sel ? (filt_level && !s_q.cap_prev)
                               : (!filt_level && s_q.cap_prev);
    assign capture  = cap_mode && cap_edge;

    // prescaler and timer clock
    assign pre_clear = (wr_ctrl_b && io_wdata[`TCC_B_PSR]) || s_q.psr;
    assign run       = !s_q.psr;
    assign ext_fall  = s_q.ext_prev && !external_clock_pin;
    assign ext_rise  = !s_q.ext_prev && external_clock_pin;

    always_comb begin
        tick = 1'b0;
        case (s_q.clk_sel)
            tcc_pkg::TCC_CS_STOP:     tick = 1'b0;
            tcc_pkg::TCC_CS_IO:       tick = 1'b1;
            tcc_pkg::TCC_CS_DIV8:     tick = (s_q.pre & `TCC_DIV8_MASK) == `TCC_DIV8_MASK;
            tcc_pkg::TCC_CS_DIV64:    tick = (s_q.pre & `TCC_DIV64_MASK) == `TCC_DIV64_MASK;
            tcc_pkg::TCC_CS_DIV256:   tick = (s_q.pre & `TCC_DIV256_MASK) == `TCC_DIV256_MASK;
            tcc_pkg::TCC_CS_DIV1024:  tick = s_q.pre == `TCC_DIV1024_MASK;
            tcc_pkg::TCC_CS_EXT_FALL: tick = ext_fall;
            tcc_pkg::TCC_CS_EXT_RISE: tick = ext_rise;
            default:                  tick = 1'b0;
        endcase
        tick = tick && run;
    end

    // compare value and counting top
    assign cmp_val  = wide ? {s_q.cmp_b, s_q.cmp_a} : {`TCC_ZERO8, s_q.cmp_a};
    assign cnt_val  = wide ? s_q.counter : {`TCC_ZERO8, s_q.counter[7:0]};
    assign top_val  = ctc_mode ? cmp_val : (wide ? `TCC_MAX16 : {`TCC_ZERO8, `TCC_MAX8});
    assign match    = cnt_val == cmp_val;
    assign at_top   = cnt_val == top_val;
    assign cmpa_set = tick && match && !cap_mode && !s_q.block;

    always_comb begin
        s_d = s_q;
        s_d.ext_prev = external_clock_pin;
        s_d.cap_prev = filt_level;
        s_d.pre      = pre_clear ? `TCC_PRE_ZERO : s_q.pre + `TCC_PRE_ONE;
        s_d.psr      = s_q.psr && s_q.sync_hold;

        // counting
        if (tick) begin
            s_d.block = 1'b0;
            if (wide) begin
                s_d.counter = at_top ? `TCC_ZERO16 : s_q.counter + `TCC_ONE16;
            end else begin
                s_d.counter[7:0] = at_top ? `TCC_ZERO8 : s_q.counter[7:0] + `TCC_ONE8;
            end
        end

        // capture into the compare pair
        if (capture) begin
            s_d.cmp_a = s_q.counter[7:0];
            if (wide) begin
                s_d.cmp_b = s_q.counter[15:8];
            end
        end

        // flags: set beats clear
        s_d.flag_cmpa = (s_q.flag_cmpa && !(wr_flags && io_wdata[`TCC_BIT_CMPA])) || cmpa_set;
        s_d.flag_cap  = (s_q.flag_cap && !(wr_flags && io_wdata[`TCC_BIT_CAP])) || capture;

        // cpu writes win over counting and capture
        if (wr_ctrl_a) begin
            s_d.ctrl_a = io_wdata & `TCC_CTRL_A_MASK;
        end
        if (wr_ctrl_b) begin
            s_d.clk_sel   = tcc_pkg::tcc_clk_sel_e'(io_wdata[`TCC_B_CS_HI:0]);
            s_d.sync_hold = io_wdata[`TCC_B_SYNC];
            s_d.psr       = io_wdata[`TCC_B_SYNC] && io_wdata[`TCC_B_PSR];
        end
        if (wr_mask) begin
            s_d.mask_cmpa = io_wdata[`TCC_BIT_CMPA];
            s_d.mask_cap  = io_wdata[`TCC_BIT_CAP];
        end
        if (wr_cnt_h) begin
            if (wide) begin
                s_d.temp = io_wdata;
            end else begin
                s_d.counter[15:8] = io_wdata;
            end
        end
        if (wr_cnt_l) begin
            s_d.block = 1'b1;
            if (wide) begin
                s_d.counter = {s_q.temp, io_wdata};
            end else begin
                s_d.counter[7:0] = io_wdata;
            end
        end
        if (wr_cmp_b) begin
            if (wide) begin
                s_d.temp = io_wdata;
            end else begin
                s_d.cmp_b = io_wdata;
            end
        end
        if (wr_cmp_a) begin
            s_d.cmp_a = io_wdata;
            if (wide) begin
                s_d.cmp_b = s_q.temp;
            end
        end

        // reads: registered data, counter low read (compare a read in capture mode) fills holding register
        if (io_re) begin
            case (io_addr)
                `TCC_ADDR_CTRL_A: s_d.rdata = s_q.ctrl_a & `TCC_CTRL_A_MASK;
                `TCC_ADDR_CTRL_B: s_d.rdata = {`TCC_ZERO3, s_q.sync_hold, s_q.psr, s_q.clk_sel};
                `TCC_ADDR_MASK:   s_d.rdata = {`TCC_ZERO3, s_q.mask_cmpa, `TCC_ZERO3, s_q.mask_cap};
                `TCC_ADDR_FLAGS:  s_d.rdata = {`TCC_ZERO3, s_q.flag_cmpa, `TCC_ZERO3, s_q.flag_cap};
                `TCC_ADDR_CNT_L:  s_d.rdata = s_q.counter[7:0];
                `TCC_ADDR_CNT_H:  s_d.rdata = wide ? s_q.temp : s_q.counter[15:8];
                `TCC_ADDR_CMP_A:  s_d.rdata = s_q.cmp_a;
                `TCC_ADDR_CMP_B:  s_d.rdata = (wide && cap_mode) ? s_q.temp : s_q.cmp_b;
                default:          s_d.rdata = `TCC_ZERO8;
            endcase
        end
        if (rd_cnt_l && wide) begin
            s_d.temp = s_q.counter[15:8];
        end
        if (rd_cmp_a && wide && cap_mode) begin
            s_d.temp = s_q.cmp_b;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata      = s_q.rdata;
    assign compare_a_irq = s_q.flag_cmpa && s_q.mask_cmpa;
    assign capture_irq   = s_q.flag_cap && s_q.mask_cap;

    // checks
    property p_match16;
        @(posedge core_clk) disable iff (reset)
        tick && wide && !cap_mode && !s_q.block && s_q.counter == {s_q.cmp_b, s_q.cmp_a}
            |=> s_q.flag_cmpa;
    endproperty
    a_match16: assert property (p_match16)
        else $error("16-bit compare match did not set flag");

    property p_match8;
        @(posedge core_clk) disable iff (reset)
        tick && !wide && !cap_mode && !s_q.block && s_q.counter[7:0] == s_q.cmp_a
            |=> s_q.flag_cmpa;
    endproperty
    a_match8: assert property (p_match8)
        else $error("8-bit compare match did not set flag");

    property p_capture;
        @(posedge core_clk) disable iff (reset)
        capture && !wr_cmp_a |=> s_q.flag_cap && s_q.cmp_a == $past(s_q.counter[7:0]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not store counter and set flag");

    property p_falling;
        @(posedge core_clk) disable iff (reset)
        cap_mode && !edge_sel && $past(filt_level) && !filt_level && !$past(reset)
            |-> capture;
    endproperty
    a_falling: assert property (p_falling)
        else $error("falling edge did not trigger capture");

    property p_no_acmp;
        @(posedge core_clk) disable iff (reset)
        !acmp_sel |-> cap_src == capture_pin;
    endproperty
    a_no_acmp: assert property (p_no_acmp)
        else $error("comparator reached capture while deselected");

    property p_reserved;
        @(posedge core_clk) disable iff (reset)
        io_re && io_addr == `TCC_ADDR_CTRL_A |=> io_rdata[2:1] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved control bits read nonzero");

    property p_ctc_clear;
        @(posedge core_clk) disable iff (reset)
        ctc_mode && wide && tick && s_q.counter == {s_q.cmp_b, s_q.cmp_a}
            && !wr_cnt_l && !wr_cnt_h |=> s_q.counter == `TCC_ZERO16;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear)
        else $error("clear on match did not clear counter");

    sequence s_sync_arm;
        wr_ctrl_b && io_wdata[`TCC_B_SYNC] && io_wdata[`TCC_B_PSR];
    endsequence
    property p_sync_hold;
        @(posedge core_clk) disable iff (reset)
        s_sync_arm ##1 (!wr_ctrl_b)[*3] |-> s_q.psr && !tick;
    endproperty
    a_sync_hold: assert property (p_sync_hold)
        else $error("prescaler reset not held in sync mode");

    property p_sync_release;
        @(posedge core_clk) disable iff (reset)
        wr_ctrl_b && !io_wdata[`TCC_B_SYNC] |=> !s_q.psr;
    endproperty
    a_sync_release: assert property (p_sync_release)
        else $error("prescaler reset not cleared on sync release");

    property p_psr_pulse;
        @(posedge core_clk) disable iff (reset)
        wr_ctrl_b && io_wdata[`TCC_B_PSR] && !io_wdata[`TCC_B_SYNC]
            |=> s_q.pre == `TCC_PRE_ZERO && !s_q.psr;
    endproperty
    a_psr_pulse: assert property (p_psr_pulse)
        else $error("prescaler reset did not clear or self clear");

    property p_stopped;
        @(posedge core_clk) disable iff (reset)
        s_q.clk_sel == tcc_pkg::TCC_CS_STOP && !wr_cnt_l && !wr_cnt_h |=> $stable(s_q.counter);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("stopped counter moved");

    property p_ext_rise;
        @(posedge core_clk) disable iff (reset)
        s_q.clk_sel == tcc_pkg::TCC_CS_EXT_RISE && run && !s_q.ext_prev && external_clock_pin
            |-> tick;
    endproperty
    a_ext_rise: assert property (p_ext_rise)
        else $error("external rising edge did not tick");

    property p_block;
        @(posedge core_clk) disable iff (reset)
        s_q.block && tick && !s_q.flag_cmpa |=> !s_q.flag_cmpa;
    endproperty
    a_block: assert property (p_block)
        else $error("match not suppressed after low byte write");

    sequence s_wr16;
        wide && wr_cnt_h ##1 !io_we && !io_re ##1 wide && wr_cnt_l;
    endsequence
    property p_wr16;
        @(posedge core_clk) disable iff (reset)
        s_wr16 |=> s_q.counter == {$past(io_wdata, 3), $past(io_wdata)};
    endproperty
    a_wr16: assert property (p_wr16)
        else $error("16-bit counter write not atomic");

    property p_rd16;
        @(posedge core_clk) disable iff (reset)
        wide && rd_cnt_l |=> s_q.temp == $past(s_q.counter[15:8]);
    endproperty
    a_rd16: assert property (p_rd16)
        else $error("low byte read did not fill holding register");

    property p_temp_hold;
        @(posedge core_clk) disable iff (reset)
        !(wide && (wr_cnt_h || wr_cmp_b || rd_cnt_l || (rd_cmp_a && cap_mode)))
            |=> $stable(s_q.temp);
    endproperty
    a_temp_hold: assert property (p_temp_hold)
        else $error("holding register changed without access");

    property p_irq;
        @(posedge core_clk) disable iff (reset)
        wr_mask && io_wdata[`TCC_BIT_CMPA] && s_q.flag_cmpa && !wr_flags |=> compare_a_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("compare a request missing with flag and enable");

endmodule
`default_nettype wire

/* File: dv/tcc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_cpu_model (
    input  wire logic                   core_clk,
    output logic      [`TCC_ADDR_W-1:0] io_addr,
    output logic      [7:0]             io_wdata,
    output logic                        io_we,
    output logic                        io_re,
    input  wire logic [7:0]             io_rdata
);
    initial begin
        io_addr = 6'h00;
        io_wdata = 8'h00;
        io_we = 1'b0;
        io_re = 1'b0;
    end
    // one-cycle write strobe, data inverted once released
    task automatic wr(input logic [`TCC_ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(negedge core_clk);
        io_we = 1'b0;
        io_wdata = ~d;
    endtask
    // read data taken one cycle after the strobe
    task automatic rd(input logic [`TCC_ADDR_W-1:0] a, output logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_re = 1'b1;
        @(negedge core_clk);
        io_re = 1'b0;
        d = io_rdata;
    endtask
endmodule
`default_nettype wire

/* File: dv/tcc_timer0_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"
module tcc_timer0_tb_top;
    logic                   core_clk = 1'b0;
    logic                   reset = 1'b1;
    logic [`TCC_ADDR_W-1:0] io_addr;
    logic [7:0]             io_wdata;
    logic                   io_we;
    logic                   io_re;
    logic [7:0]             io_rdata;
    logic                   capture_pin = 1'b0;
    logic                   comparator_out = 1'b0;
    logic                   external_clock_pin = 1'b1;
    logic                   compare_a_irq;
    logic                   capture_irq;
    logic [7:0]             rnd = 8'h5e;
    logic [7:0]             v;
    int                     fail_count = 0;
    int                     checks = 0;
    int                     m_cnt;
    logic [7:0]             cap_q [$];
    int                     divs [5] = '{1, 8, 64, 256, 1024};

    always #5 core_clk = ~core_clk;

    tcc_cpu_model tcc_cpu_model_inst (
        .core_clk(core_clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata)
    );
    tcc_timer0 tcc_timer0_inst (
        .core_clk(core_clk), .reset(reset), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .capture_pin(capture_pin),
        .comparator_out(comparator_out), .external_clock_pin(external_clock_pin),
        .compare_a_irq(compare_a_irq), .capture_irq(capture_irq)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [`TCC_ADDR_W-1:0] a, input logic [7:0] d);
        tcc_cpu_model_inst.wr(a, d);
    endtask
    task automatic rdc(input logic [`TCC_ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] d;
        tcc_cpu_model_inst.rd(a, d);
        chk(d, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        rdc(`TCC_ADDR_CTRL_B, 8'h00);
        rdc(`TCC_ADDR_MASK, 8'h00);
        wr(6'h00, 8'hff);
        rdc(6'h00, 8'h00);
        wr(`TCC_ADDR_CTRL_A, 8'hff);
        rdc(`TCC_ADDR_CTRL_A, 8'hf9);
        $display("done: registers");
        for (int w = 0; w < 2; w++) begin
            wr(`TCC_ADDR_CTRL_A, w[0] ? 8'h80 : 8'h00);
            rnd = lfsr(rnd);
            m_cnt = w ? int'({rnd, 8'hff}) : 255;
            wr(`TCC_ADDR_CNT_H, rnd);
            wr(`TCC_ADDR_CNT_L, 8'hff);
            wr(`TCC_ADDR_CMP_A, 8'h3c);
            wr(`TCC_ADDR_CTRL_B, 8'h01);
            wr(`TCC_ADDR_CTRL_B, 8'h00);
            repeat (2) m_cnt = (m_cnt + 1) % (w ? 65536 : 256);
            rdc(`TCC_ADDR_CNT_L, m_cnt[7:0]);
            rdc(`TCC_ADDR_CNT_H, w[0] ? m_cnt[15:8] : rnd);
            rdc(`TCC_ADDR_CMP_B, w[0] ? rnd : 8'h00);
        end
        $display("done: width");
        wr(`TCC_ADDR_CTRL_A, 8'h00);
        wr(`TCC_ADDR_CTRL_B, 8'h08);
        rdc(`TCC_ADDR_CTRL_B, 8'h00);
        for (int c = 1; c < 6; c++) begin
            wr(`TCC_ADDR_CNT_L, 8'h00);
            wr(`TCC_ADDR_CTRL_B, 8'h18 | c[7:0]);
            idle(20);
            rdc(`TCC_ADDR_CTRL_B, 8'h18 | c[7:0]);
            rdc(`TCC_ADDR_CNT_L, 8'h00);
            wr(`TCC_ADDR_CTRL_B, c[7:0]);
            idle(4 * divs[c-1] + divs[c-1] / 2 - 2);
            wr(`TCC_ADDR_CTRL_B, 8'h00);
            rdc(`TCC_ADDR_CNT_L, 8'h04);
        end
        for (int c = 6; c < 8; c++) begin
            wr(`TCC_ADDR_CNT_L, 8'h00);
            wr(`TCC_ADDR_CTRL_B, c[7:0]);
            repeat (3) begin
                idle(2);
                external_clock_pin = 1'b0;
                idle(2);
                external_clock_pin = 1'b1;
            end
            idle(2);
            wr(`TCC_ADDR_CTRL_B, 8'h00);
            rdc(`TCC_ADDR_CNT_L, 8'h03);
        end
        $display("done: clock select");
        wr(`TCC_ADDR_CMP_A, 8'h10);
        wr(`TCC_ADDR_MASK, 8'h11);
        rdc(`TCC_ADDR_MASK, 8'h11);
        wr(`TCC_ADDR_CTRL_B, 8'h01);
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h0e : 8'h10;
            wr(`TCC_ADDR_CNT_L, v);
            idle(6);
            chk({7'h00, compare_a_irq}, {7'h00, i[0]});
        end
        wr(`TCC_ADDR_MASK, 8'h01);
        chk({7'h00, compare_a_irq}, 8'h00);
        rdc(`TCC_ADDR_FLAGS, 8'h10);
        wr(`TCC_ADDR_CTRL_B, 8'h00);
        wr(`TCC_ADDR_FLAGS, 8'h10);
        rdc(`TCC_ADDR_FLAGS, 8'h00);
        $display("done: compare");
        wr(`TCC_ADDR_CTRL_A, 8'h01);
        wr(`TCC_ADDR_CMP_A, 8'h03);
        wr(`TCC_ADDR_CNT_L, 8'h00);
        wr(`TCC_ADDR_CTRL_B, 8'h01);
        idle(7);
        wr(`TCC_ADDR_CTRL_B, 8'h00);
        m_cnt = 0;
        repeat (9) m_cnt = (m_cnt == 3) ? 0 : m_cnt + 1;
        rdc(`TCC_ADDR_CNT_L, m_cnt[7:0]);
        rdc(`TCC_ADDR_FLAGS, 8'h10);
        wr(`TCC_ADDR_MASK, 8'h11);
        chk({7'h00, compare_a_irq}, 8'h01);
        wr(`TCC_ADDR_FLAGS, 8'h10);
        $display("done: clear on match");
        for (int i = 0; i < 8; i++) begin
            wr(`TCC_ADDR_CTRL_A, 8'h40 | {2'h0, i[2], i[0], i[1], 3'h0});
            capture_pin = ~i[0];
            comparator_out = ~i[0];
            rnd = lfsr(rnd);
            wr(`TCC_ADDR_CNT_L, rnd);
            cap_q.push_back(rnd);
            idle(8);
            wr(`TCC_ADDR_FLAGS, 8'h01);
            if (i[1]) capture_pin = i[0];
            else comparator_out = i[0];
            idle(10);
            chk({7'h00, capture_irq}, 8'h00);
            if (i[1]) comparator_out = i[0];
            else capture_pin = i[0];
            idle(4);
            chk({7'h00, capture_irq}, {7'h00, ~i[2]});
            idle(6);
            chk({7'h00, capture_irq}, 8'h01);
            rdc(`TCC_ADDR_CMP_A, cap_q.pop_front());
        end
        $display("done: capture");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end
endmodule
`default_nettype wire
